// ===== rtl/wdtr_pkg.sv
// Constants, types and register map of the watchdog timer block
// Overview of operation
// - The watchdog is an 8-bit counter behind an 11-bit prescaler.
// - Prescaler input is oscillator over six; counter steps every 2048 inputs.
// - Counter overflow produces a short pulse that resets the whole controller.
// - Overflow also pulls the active-low reset pin low for three machine cycles.
// - Internal reset acts even if a pin capacitor swallows the pin pulse.
// - Counting starts only once software sets the enable bit, auxiliary bit 4.
// - Software cannot clear the enable bit; only a reset clears it.
// - Any counter write clears the load permit automatically.
// - With the load permit clear, counter writes are ignored.
// - Counter counts up from the reload value; 00H longest, 0FFH shortest.
// - Prescaler and counter keep running while the processor idles.
// - While enabled, setting the power-down bit is ignored and it reads 0.
// - The counter is a register at index 0FFH.
package wdtr_pkg;

  localparam int unsigned WDTR_AW = 12;
  localparam int unsigned WDTR_DW = 32;
  localparam int unsigned WDTR_CW = 8;

  // Register index as printed, byte address is four times the index
  localparam logic [7:0] WDTR_CNT_INDEX = 8'hFF;
  localparam logic [WDTR_AW-1:0] WDTR_CNT_ADDR = {2'h0, WDTR_CNT_INDEX, 2'h0};
  localparam logic [WDTR_AW-1:0] WDTR_AUX_ADDR = 12'h000;
  localparam logic [WDTR_AW-1:0] WDTR_PWR_ADDR = 12'h004;
  localparam logic [WDTR_AW-1:0] WDTR_STAT_ADDR = 12'h008;

  // Field positions
  localparam int unsigned WDTR_AUX_EN_BIT = 4;
  localparam int unsigned WDTR_PWR_PD_BIT = 1;
  localparam int unsigned WDTR_PWR_LE_BIT = 4;
  localparam int unsigned WDTR_STAT_SEEN_BIT = 0;
  localparam int unsigned WDTR_STAT_PULSE_BIT = 1;

  // Reset values and counter top value
  localparam logic [WDTR_CW-1:0] WDTR_CNT_RST = 8'h00;
  localparam logic [WDTR_CW-1:0] WDTR_CNT_MAX = 8'hFF;
  localparam logic [WDTR_DW-1:0] WDTR_RDATA_RST = 32'h0000_0000;

  // Timing: default divider and prescaler width, pin pulse length
  localparam int unsigned WDTR_OSC_DIV = 6;
  localparam int unsigned WDTR_PRESC_W = 11;
  localparam int unsigned WDTR_MC_CLKS = 6;
  localparam int unsigned WDTR_PULSE_MC = 3;
  localparam int unsigned WDTR_PULSE_CLKS = WDTR_MC_CLKS * WDTR_PULSE_MC;
  localparam int unsigned WDTR_PULSE_W = 5;

  typedef enum logic [1:0] {
    WDTR_RP_IDLE = 2'b00,
    WDTR_RP_DRIVE = 2'b01,
    WDTR_RP_TAIL = 2'b11
  } wdtr_rp_state_type;

  typedef enum logic [2:0] {
    WDTR_SEL_NONE = 3'h0,
    WDTR_SEL_AUX = 3'h1,
    WDTR_SEL_PWR = 3'h2,
    WDTR_SEL_CNT = 3'h3,
    WDTR_SEL_STAT = 3'h4
  } wdtr_sel_type;

  typedef struct packed {
    logic [WDTR_AW-1:0] addr;
    logic write;
    logic [WDTR_DW-1:0] wdata;
  } wdtr_apb_req_type;

endpackage

// ===== rtl/wdtr_prescaler.sv
// Oscillator divider and prescaler producing the counter step enable
`timescale 1ns/10ps
module wdtr_prescaler import wdtr_pkg::*; #(
  parameter int unsigned OSC_DIV = WDTR_OSC_DIV,
  parameter int unsigned PRESC_W = WDTR_PRESC_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clear,
  output logic tick_q
);

  localparam int unsigned DIV_W = $clog2(OSC_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  localparam logic [PRESC_W-1:0] PRESC_LAST = '1;
  localparam logic [PRESC_W-1:0] PRESC_ZERO = '0;

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_d;
  logic tick_d;

  // Nothing here looks at idle; the chain runs in every processor mode
  always_comb begin
    div_d = div_q;
    presc_d = presc_q;
    tick_d = 1'b0;
    if (clear) begin
      div_d = DIV_ZERO;
      presc_d = PRESC_ZERO;
    end else if (div_q == DIV_LAST) begin
      div_d = DIV_ZERO;
      presc_d = presc_q + 1'b1;
      tick_d = (presc_q == PRESC_LAST);
    end else begin
      div_d = div_q + 1'b1;
    end
  end

  // Divider state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= DIV_ZERO;
      presc_q <= PRESC_ZERO;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      presc_q <= presc_d;
      tick_q <= tick_d;
    end
  end

endmodule

// ===== rtl/wdtr_reset_pulse.sv
// Reset pulse generator for the internal reset and the reset pin
`timescale 1ns/10ps
module wdtr_reset_pulse import wdtr_pkg::*; (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic start,
  output logic sys_reset_q,
  output logic pin_drive_q
);

  localparam logic [WDTR_PULSE_W-1:0] LEN_LAST = WDTR_PULSE_W'(WDTR_PULSE_CLKS - 1);
  localparam logic [WDTR_PULSE_W-1:0] LEN_ZERO = '0;

  wdtr_rp_state_type state_q;
  wdtr_rp_state_type state_d;
  logic [WDTR_PULSE_W-1:0] len_q;
  logic [WDTR_PULSE_W-1:0] len_d;
  logic sys_reset_d;
  logic pin_drive_d;

  // Internal reset and pin pulse share one timer, so the internal side
  // never depends on what the pin level does
  always_comb begin
    state_d = state_q;
    len_d = len_q;
    sys_reset_d = 1'b0;
    pin_drive_d = 1'b0;
    case (state_q)
      WDTR_RP_IDLE: begin
        if (start) begin
          state_d = WDTR_RP_DRIVE;
          len_d = LEN_ZERO;
          sys_reset_d = 1'b1;
          pin_drive_d = 1'b1;
        end
      end
      WDTR_RP_DRIVE: begin
        sys_reset_d = 1'b1;
        pin_drive_d = 1'b1;
        len_d = len_q + 1'b1;
        if (len_q == LEN_LAST - 1'b1) begin
          state_d = WDTR_RP_TAIL;
        end
      end
      WDTR_RP_TAIL: begin
        state_d = WDTR_RP_IDLE;
        len_d = LEN_ZERO;
      end
      default: begin
        state_d = WDTR_RP_IDLE;
        len_d = LEN_ZERO;
      end
    endcase
  end

  // Pulse state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= WDTR_RP_IDLE;
      len_q <= LEN_ZERO;
      sys_reset_q <= 1'b0;
      pin_drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      len_q <= len_d;
      sys_reset_q <= sys_reset_d;
      pin_drive_q <= pin_drive_d;
    end
  end

endmodule

// ===== rtl/wdtr_top.sv
// Watchdog timer with APB register access and reset pin driver
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module wdtr_top import wdtr_pkg::*; #(
  parameter int unsigned OSC_DIV = WDTR_OSC_DIV,
  parameter int unsigned PRESC_W = WDTR_PRESC_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [WDTR_AW-1:0] paddr,
  input wire logic [WDTR_DW-1:0] pwdata,
  output logic [WDTR_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sys_reset,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic power_down,
  output logic watchdog_running
);

  // Request as seen on the bus
  wdtr_apb_req_type req;
  assign req.addr = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;

  // Address decoding shared by the read and write paths
  function automatic wdtr_sel_type reg_select(input logic [WDTR_AW-1:0] addr);
    wdtr_sel_type sel;
    sel = WDTR_SEL_NONE;
    if (addr == WDTR_AUX_ADDR) begin
      sel = WDTR_SEL_AUX;
    end else if (addr == WDTR_PWR_ADDR) begin
      sel = WDTR_SEL_PWR;
    end else if (addr == WDTR_CNT_ADDR) begin
      sel = WDTR_SEL_CNT;
    end else if (addr == WDTR_STAT_ADDR) begin
      sel = WDTR_SEL_STAT;
    end
    return sel;
  endfunction

  // Bus side state
  logic pready_q;
  logic pready_d;
  logic [WDTR_DW-1:0] prdata_q;
  logic [WDTR_DW-1:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  // Watchdog control state
  logic enable_q;
  logic enable_d;
  logic load_permit_q;
  logic load_permit_d;
  logic power_down_q;
  logic power_down_d;
  logic [WDTR_CW-1:0] count_q;
  logic [WDTR_CW-1:0] count_d;
  logic seen_q;
  logic seen_d;
  logic running_q;
  logic running_d;

  // Derived strobes
  logic access;
  logic commit;
  logic wr_commit;
  wdtr_sel_type sel;
  logic tick;
  logic overflow;
  logic pulse_sys;
  logic pulse_pin;
  logic presc_clear;

  assign access = psel & penable;
  assign commit = access & pready_q;
  assign wr_commit = commit & req.write;
  assign sel = reg_select(req.addr);

  // Overflow is the step that carries the counter past its top value
  assign overflow = enable_q & tick & (count_q == WDTR_CNT_MAX);

  // Prescaler held clear while disabled so counting starts from zero
  assign presc_clear = ~enable_q | overflow;

  wdtr_prescaler #(
    .OSC_DIV(OSC_DIV),
    .PRESC_W(PRESC_W)
  ) u_presc (
    .mclk(mclk),
    .arst_n(arst_n),
    .clear(presc_clear),
    .tick_q(tick)
  );

  wdtr_reset_pulse u_pulse (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(overflow),
    .sys_reset_q(pulse_sys),
    .pin_drive_q(pulse_pin)
  );

  // Read data for the register that the bus is addressing
  function automatic logic [WDTR_DW-1:0] read_value(
    input wdtr_sel_type s,
    input logic en,
    input logic le,
    input logic pd,
    input logic [WDTR_CW-1:0] cnt,
    input logic sn,
    input logic pl
  );
    logic [WDTR_DW-1:0] v;
    v = '0;
    if (s == WDTR_SEL_AUX) begin
      v[WDTR_AUX_EN_BIT] = en;
    end else if (s == WDTR_SEL_PWR) begin
      v[WDTR_PWR_LE_BIT] = le;
      v[WDTR_PWR_PD_BIT] = pd & ~en;
    end else if (s == WDTR_SEL_CNT) begin
      v[WDTR_CW-1:0] = cnt;
    end else if (s == WDTR_SEL_STAT) begin
      v[WDTR_STAT_SEEN_BIT] = sn;
      v[WDTR_STAT_PULSE_BIT] = pl;
    end
    return v;
  endfunction

  // Bus answer: one wait cycle, data and error sampled with ready
  always_comb begin
    pready_d = access & ~pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (access & ~pready_q) begin
      pslverr_d = (sel == WDTR_SEL_NONE);
      if (req.write) begin
        prdata_d = WDTR_RDATA_RST;
      end else begin
        prdata_d = read_value(sel, enable_q, load_permit_q, power_down_q,
                              count_q, seen_q, pulse_sys);
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      prdata_q <= WDTR_RDATA_RST;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Watchdog control: software writes, counting and overflow clearing.
  // Overflow acts as a system reset on this block's own state, and it
  // takes priority over a write landing in the same cycle.
  always_comb begin
    enable_d = enable_q;
    load_permit_d = load_permit_q;
    power_down_d = power_down_q;
    count_d = count_q;
    seen_d = seen_q;

    // Counting, also while the processor idles
    if (enable_q & tick) begin
      count_d = count_q + 1'b1;
    end

    if (wr_commit) begin
      if (sel == WDTR_SEL_AUX) begin
        // Write of one sets; a zero never clears
        if (req.wdata[WDTR_AUX_EN_BIT]) begin
          enable_d = 1'b1;
        end else begin
          enable_d = enable_q;
        end
      end else if (sel == WDTR_SEL_PWR) begin
        load_permit_d = req.wdata[WDTR_PWR_LE_BIT];
        if (enable_q) begin
          power_down_d = 1'b0;
        end else begin
          power_down_d = req.wdata[WDTR_PWR_PD_BIT];
        end
      end else if (sel == WDTR_SEL_CNT) begin
        if (load_permit_q) begin
          count_d = req.wdata[WDTR_CW-1:0];
          load_permit_d = 1'b0;
        end else begin
          count_d = count_d;
        end
      end
    end

    // Power-down cannot coexist with a live watchdog
    if (enable_d) begin
      power_down_d = 1'b0;
    end

    if (overflow) begin
      enable_d = 1'b0;
      load_permit_d = 1'b0;
      power_down_d = 1'b0;
      count_d = WDTR_CNT_RST;
      seen_d = 1'b1;
    end
  end

  // Running indication is the enable as it gets registered
  always_comb begin
    running_d = enable_d;
  end

  // Control registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= 1'b0;
      load_permit_q <= 1'b0;
      power_down_q <= 1'b0;
      count_q <= WDTR_CNT_RST;
      seen_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      load_permit_q <= load_permit_d;
      power_down_q <= power_down_d;
      count_q <= count_d;
      seen_q <= seen_d;
      running_q <= running_d;
    end
  end

  // Pin and reset outputs, retimed so sys_reset and rst_pin_oe leave a flip-flop.
  // The pin is open drain: it only ever pulls low and never drives high.
  logic sys_reset_q;
  logic rst_pin_oe_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sys_reset_q <= 1'b0;
      rst_pin_oe_q <= 1'b0;
    end else begin
      sys_reset_q <= pulse_sys;
      rst_pin_oe_q <= pulse_pin;
    end
  end

  // Output ports
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sys_reset = sys_reset_q;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = rst_pin_oe_q;
  assign power_down = power_down_q;
  assign watchdog_running = running_q;

endmodule

// ===== sim/wdtr_props.sv
// Port-level assertions for the watchdog timer top
`timescale 1ns/10ps
module wdtr_props import wdtr_pkg::*; #(
  parameter int unsigned OSC_DIV = WDTR_OSC_DIV,
  parameter int unsigned PRESC_W = WDTR_PRESC_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [WDTR_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_reset,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  input wire logic power_down,
  input wire logic watchdog_running
);
  localparam logic [4:0] PULSE_LEN = 5'(WDTR_PULSE_CLKS);
  logic [4:0] oe_cnt_q;
  logic [4:0] oe_cnt_d;

  // Length of the pin pulse so far; wraps harmlessly past 31
  always_comb begin
    oe_cnt_d = rst_pin_oe ? oe_cnt_q + 5'h01 : 5'h00;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      oe_cnt_q <= 5'h00;
    end else begin
      oe_cnt_q <= oe_cnt_d;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // Bus cycle steps
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence

  property p_pin_len;
    $fell(rst_pin_oe) |-> oe_cnt_q == PULSE_LEN;
  endproperty
  a_pin_len: assert property (p_pin_len) else $error("pin pulse length wrong");
  property p_pin_low;
    rst_pin_oe |-> !rst_pin_o;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  property p_int_pin;
    $rose(sys_reset) |-> $rose(rst_pin_oe);
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("pulses not together");
  property p_from_run;
    $rose(sys_reset) |-> $past(watchdog_running, 2);
  endproperty
  a_from_run: assert property (p_from_run) else $error("reset while stopped");
  property p_en_sticky;
    $fell(watchdog_running) |-> ##[0:2] sys_reset;
  endproperty
  a_en_sticky: assert property (p_en_sticky) else $error("enable dropped");
  property p_pd_block;
    watchdog_running |-> !power_down;
  endproperty
  a_pd_block: assert property (p_pd_block) else $error("power down while running");
  property p_ready;
    s_setup ##1 s_wait |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in second cycle");
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready too long");
  property p_err_zero;
    pready && pslverr |-> prdata == '0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
endmodule

bind wdtr_top wdtr_props #(.OSC_DIV(OSC_DIV), .PRESC_W(PRESC_W)) wdtr_props_i (
  .mclk(mclk),
  .arst_n(arst_n),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .sys_reset(sys_reset),
  .rst_pin_o(rst_pin_o),
  .rst_pin_oe(rst_pin_oe),
  .power_down(power_down),
  .watchdog_running(watchdog_running)
);

// ===== sim/wdtr_top_tb.sv
// Self-checking bench for the watchdog timer top
`timescale 1ns/10ps
`define CHK(got, want) begin checks_done++; if ((got) !== (want)) begin num_errors++; \
  $display("BAD %0t: got %h want %h", $time, got, want); end end
module wdtr_top_tb import wdtr_pkg::*;;
  localparam int STEP = 2 * 4;
  logic mclk, arst_n, psel, penable, pwrite;
  logic [WDTR_AW-1:0] paddr;
  logic [WDTR_DW-1:0] pwdata, prdata, r;
  logic pready, pslverr, sys_reset, rst_pin_o, rst_pin_oe, power_down, watchdog_running;
  logic [WDTR_DW:0] exp_q[$];
  int seed, num_errors, checks_done;

  // Short prescaler so an overflow takes at most 2048 clocks
  wdtr_top #(.OSC_DIV(2), .PRESC_W(2)) wdtr_top_i (.mclk(mclk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_reset(sys_reset),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .power_down(power_down),
    .watchdog_running(watchdog_running));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One bus transfer; an idle cycle follows so no signal is set twice
  task automatic xfer(input logic w, input logic [WDTR_AW-1:0] a,
                      input logic [WDTR_DW-1:0] d, input logic [WDTR_DW:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("BAD %0t: no ready from slave", $time);
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [WDTR_AW-1:0] a, input logic [WDTR_DW-1:0] d);
    xfer(1'h1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [WDTR_AW-1:0] a, input logic [WDTR_DW-1:0] v);
    xfer(1'h0, a, 32'h0, {1'h0, v});
  endtask

  // Enable, reload with k, then time the overflow and the pulse
  task automatic run_out(input logic [7:0] k);
    int n;
    int m;
    n = 0;
    m = 0;
    wr(WDTR_AUX_ADDR, 32'h10);
    wr(WDTR_PWR_ADDR, 32'h10);
    wr(WDTR_CNT_ADDR, {24'h0, k});
    while (sys_reset !== 1'h1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    `CHK(n >= (255 - k) * STEP && n <= (256 - k) * STEP + 3, 1'h1)
    while (sys_reset === 1'h1 && m < 100) begin
      `CHK({rst_pin_oe, rst_pin_o}, 2'h2)
      @(posedge mclk);
      m++;
    end
    `CHK(m, WDTR_PULSE_CLKS)
    rd(WDTR_AUX_ADDR, 32'h0);
    rd(WDTR_STAT_ADDR, 32'h1);
  endtask

  // Results are matched in order against the notes of the driver
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'h1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("BAD %0t: answer with no request noted", $time);
      end else `CHK({pslverr, prdata}, exp_q.pop_front())
    end
  end

  // Hang guard, well beyond the expected run length
  initial begin
    #(40 * 30000);
    num_errors++;
    $display("BAD %0t: run timed out", $time);
    report_and_stop;
  end

  initial begin
    seed = 60;
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    `CHK({watchdog_running, sys_reset, rst_pin_oe}, 3'h0)
    rd(WDTR_AUX_ADDR, 32'h0);
    rd(WDTR_PWR_ADDR, 32'h0);
    rd(WDTR_CNT_ADDR, 32'h0);
    xfer(1'h1, 12'h100, $random(seed), {1'h1, 32'h0});
    wr(WDTR_CNT_ADDR, $random(seed));
    rd(WDTR_CNT_ADDR, 32'h0);
    r = $random(seed) & 32'h7F;
    wr(WDTR_PWR_ADDR, 32'h10);
    rd(WDTR_PWR_ADDR, 32'h10);
    wr(WDTR_CNT_ADDR, r);
    rd(WDTR_CNT_ADDR, r);
    rd(WDTR_PWR_ADDR, 32'h0);
    wr(WDTR_CNT_ADDR, r ^ 32'h1);
    rd(WDTR_CNT_ADDR, r);
    wr(WDTR_PWR_ADDR, 32'h2);
    rd(WDTR_PWR_ADDR, 32'h2);
    `CHK(power_down, 1'h1)
    wr(WDTR_PWR_ADDR, 32'h0);
    wr(WDTR_AUX_ADDR, 32'h10);
    wr(WDTR_AUX_ADDR, 32'h0);
    rd(WDTR_AUX_ADDR, 32'h10);
    `CHK(watchdog_running, 1'h1)
    wr(WDTR_PWR_ADDR, 32'h2);
    rd(WDTR_PWR_ADDR, 32'h0);
    `CHK(power_down, 1'h0)
    // Reloads well inside the interval keep the watchdog from firing
    repeat (4) begin
      wr(WDTR_PWR_ADDR, 32'h10);
      wr(WDTR_CNT_ADDR, 32'hC0);
      repeat (100) @(posedge mclk);
      `CHK({sys_reset, rst_pin_oe}, 2'h0)
    end
    rd(WDTR_STAT_ADDR, 32'h0);
    run_out(8'hFF);
    run_out(8'h00);
    r = $random(seed);
    run_out(r[7:0]);
    // Second reset in mid-count clears everything again
    wr(WDTR_AUX_ADDR, 32'h10);
    arst_n <= 1'h0;
    @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    rd(WDTR_AUX_ADDR, 32'h0);
    rd(WDTR_STAT_ADDR, 32'h0);
    report_and_stop;
  end
endmodule
